// >>> hdl/boot_pkg.sv
package boot_pkg;
    // alternating handshake word, default values
    localparam logic [7:0] PAT_A_DEF = 8'h12;
    localparam logic [7:0] PAT_B_DEF = 8'h9A;
    // countdown after the pattern is first seen
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] COUNT_LOAD = 8'h3F;
    localparam logic [CNT_W-1:0] COUNT_END = 8'h00;
    localparam logic [CNT_W-1:0] COUNT_STEP = 8'h01;
    // critical core inputs held while the handoff is pending
    localparam int CRIT_W = 4;
    localparam logic [CRIT_W-1:0] CRIT_IDLE = 4'h0;
    // drain completer, then reset values for the previous sample and the pin synchronizers
    localparam int TAG_W = 8;
    localparam logic [31:0] CPL_ZERO = 32'h0000_0000;
    localparam logic [TAG_W-1:0] TAG_RST = 8'h00;
    localparam logic [7:0] PAT_RST = 8'h00;
    localparam logic [1:0] SYNC_RST = 2'b00;

    typedef enum logic [1:0] {
        ST_SEEK = 2'b00,
        ST_COUNT = 2'b01,
        ST_READY = 2'b10
    } hand_st_e;

    // true when cur follows prev in the alternating sequence
    function automatic logic alt_step(input logic [7:0] cur, input logic [7:0] prev,
                                      input logic [7:0] pa, input logic [7:0] pb);
        alt_step = ((cur == pa) && (prev == pb)) || ((cur == pb) && (prev == pa));
    endfunction
endpackage

// >>> hdl/drain_if.sv
`timescale 1ns/10ps
// request/completion path between the handoff top and the drain completer
interface drain_if;
    logic req_valid;
    logic req_read;
    logic [boot_pkg::TAG_W-1:0] req_tag;
    logic req_ready;
    logic active;
    logic cpl_valid;
    logic cpl_ready;
    logic [boot_pkg::TAG_W-1:0] cpl_tag;
    logic [31:0] cpl_data;

    modport top (
        output req_valid, req_read, req_tag, active, cpl_ready,
        input req_ready, cpl_valid, cpl_tag, cpl_data
    );
    modport comp (
        input req_valid, req_read, req_tag, active, cpl_ready,
        output req_ready, cpl_valid, cpl_tag, cpl_data
    );
endinterface

// >>> hdl/drain_completer.sv
`timescale 1ns/10ps
module drain_completer (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // request and completion path
    drain_if.comp dif
);
    import boot_pkg::*;

    logic ready_q;
    logic cpl_valid_q;
    logic [TAG_W-1:0] cpl_tag_q;

    // request taken, read or other, completion still held
    wire take = dif.req_valid && ready_q;
    wire take_rd = take && dif.req_read;
    wire cpl_hold = cpl_valid_q && !dif.cpl_ready;
    wire cpl_valid_d = take_rd || cpl_hold; // [RQ7]
    // at most one completion in flight; ready drops at handoff
    wire ready_d = dif.active && !cpl_valid_d; // [RQ9]

    // non-reads are taken and forgotten, no completion is made
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ready_q <= 1'b0;
            cpl_valid_q <= 1'b0;
            cpl_tag_q <= TAG_RST;
        end else if (clk_en) begin
            ready_q <= ready_d; // [RQ8]
            cpl_valid_q <= cpl_valid_d;
            if (take_rd) begin
                cpl_tag_q <= dif.req_tag;
            end
        end
    end

    assign dif.req_ready = ready_q;
    assign dif.cpl_valid = cpl_valid_q;
    assign dif.cpl_tag = cpl_tag_q;
    assign dif.cpl_data = CPL_ZERO; // [RQ7]

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    read_cpl_a: assert property ( // [RQ7]
        clk_en && take_rd |=> cpl_valid_q && dif.cpl_data == CPL_ZERO
            && cpl_tag_q == $past(dif.req_tag) && !ready_q)
        else $error("read request not answered by zero completion");
    purge_other_a: assert property ( // [RQ8]
        clk_en && take && !dif.req_read && !cpl_valid_q |=> !cpl_valid_q)
        else $error("discarded request produced a completion");
    idle_after_a: assert property ( // [RQ9]
        clk_en && !dif.active |=> !ready_q [*3])
        else $error("completer accepts requests after handoff");
    cov_read_c: cover property (clk_en && take_rd ##[1:20] dif.cpl_ready && cpl_valid_q);
    cov_drop_c: cover property (clk_en && take && !dif.req_read);
endmodule

// >>> hdl/staged_boot_handoff.sv
`timescale 1ns/10ps
// Behaviour
// RQ1: second-stage logic drives an 8-bit word alternating two values every clock.
// RQ2: that word starts only after second-stage configuration and start-up.
// RQ3: checker watches for the alternating sequence and starts a countdown on it.
// RQ4: countdown expiry raises application-ready, handing control to user logic.
// RQ5: while not ready, critical core inputs are held deasserted.
// RQ6: once ready, critical inputs pass the user values unchanged.
// RQ7: before handoff each read request gets a zero 32-bit data completion.
// RQ8: before handoff every other request is drained with no response.
// RQ9: after handoff the drain completer takes no more requests.
// RQ10: configuration-done pulses at first start-up, then stays high after stage two.
// RQ11: first stage uses only the low-active system reset; shared-bank pins undefined.
// RQ12: second-stage parts needing init avoid that bank unless on core user reset.
// RQ13: any broken alternation before expiry reloads the counter and restarts detection.
module staged_boot_handoff #(
    parameter logic [7:0] PAT_A = boot_pkg::PAT_A_DEF,
    parameter logic [7:0] PAT_B = boot_pkg::PAT_B_DEF
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // handshake word from second-stage logic
    input wire logic [7:0] pattern_in,
    // configuration controller pins
    input wire logic startup_pin,
    input wire logic stage2_done_pin,
    output logic cfg_done,
    // handoff status
    output logic app_rdy,
    // critical core inputs
    input wire logic [boot_pkg::CRIT_W-1:0] user_crit_in,
    output logic [boot_pkg::CRIT_W-1:0] crit_out,
    // receive requests from the core buffer
    input wire logic rx_valid,
    input wire logic rx_read,
    input wire logic [boot_pkg::TAG_W-1:0] rx_tag,
    output logic rx_ready,
    // completions toward the core
    output logic cpl_valid,
    output logic [boot_pkg::TAG_W-1:0] cpl_tag,
    output logic [31:0] cpl_data,
    input wire logic cpl_ready
);
    import boot_pkg::*;

    hand_st_e st_q;
    hand_st_e st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [7:0] prev_q;
    logic app_rdy_q;
    logic [CRIT_W-1:0] crit_q;
    logic [1:0] start_sync_q;
    logic [1:0] done2_sync_q;
    logic cfg_done_q;
    drain_if dif ();

    // configuration pins come from outside the clock domain
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            start_sync_q <= SYNC_RST;
            done2_sync_q <= SYNC_RST;
        end else if (clk_en) begin
            start_sync_q <= {start_sync_q[0], startup_pin};
            done2_sync_q <= {done2_sync_q[0], stage2_done_pin};
        end
    end

    // handshake word detection; the word is only meaningful once the
    // second stage has started, so garbage before then just fails the match
    wire alt_ok = alt_step(pattern_in, prev_q, PAT_A, PAT_B); // [RQ1] [RQ2]
    wire cnt_zero = (cnt_q == COUNT_END);
    wire [CNT_W-1:0] cnt_dec = cnt_q - COUNT_STEP;

    // next state of the checker and countdown
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            ST_SEEK: begin
                if (alt_ok) begin
                    st_d = ST_COUNT; // [RQ3]
                    cnt_d = COUNT_LOAD;
                end
            end
            ST_COUNT: begin
                if (!alt_ok) begin
                    st_d = ST_SEEK; // [RQ13]
                    cnt_d = COUNT_LOAD;
                end else if (cnt_zero) begin
                    st_d = ST_READY; // [RQ4]
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_READY: begin
                st_d = ST_READY;
            end
            default: begin
                st_d = ST_SEEK;
                cnt_d = COUNT_LOAD;
            end
        endcase
    end

    wire rdy_d = (st_d == ST_READY);

    // checker state, previous sample and the ready flag
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_SEEK;
            cnt_q <= COUNT_LOAD;
            prev_q <= PAT_RST;
            app_rdy_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            prev_q <= pattern_in;
            app_rdy_q <= rdy_d; // [RQ4]
        end
    end

    // critical input multiplexers, selected by application-ready
    wire [CRIT_W-1:0] crit_sel = app_rdy_q ? user_crit_in : CRIT_IDLE; // [RQ5] [RQ6]

    // done indicator: follows start-up pulse, then stage-two completion
    wire cfg_done_d = start_sync_q[1] || done2_sync_q[1]; // [RQ10]

    // registered outputs; only nrst resets this logic, no other bank pin is used
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            crit_q <= CRIT_IDLE; // [RQ11]
            cfg_done_q <= 1'b0;
        end else if (clk_en) begin
            crit_q <= crit_sel;
            cfg_done_q <= cfg_done_d;
        end
    end

    // drain completer works only until the handoff
    assign dif.req_valid = rx_valid;
    assign dif.req_read = rx_read;
    assign dif.req_tag = rx_tag;
    assign dif.cpl_ready = cpl_ready;
    assign dif.active = !rdy_d; // [RQ9]

    drain_completer u_drain (
        .sys_clk (sys_clk),
        .nrst (nrst),
        .clk_en (clk_en),
        .dif (dif.comp)
    );

    // outputs, each from a flip-flop except the constant cpl_data
    assign app_rdy = app_rdy_q;
    assign crit_out = crit_q;
    assign cfg_done = cfg_done_q;
    assign rx_ready = dif.req_ready;
    assign cpl_valid = dif.cpl_valid;
    assign cpl_tag = dif.cpl_tag;
    assign cpl_data = dif.cpl_data;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    detect_start_a: assert property ( // [RQ3]
        clk_en && st_q == ST_SEEK && alt_ok |=> st_q == ST_COUNT && cnt_q == COUNT_LOAD)
        else $error("detected pattern did not start the countdown");
    restart_a: assert property ( // [RQ13]
        clk_en && st_q == ST_COUNT && !alt_ok |=> st_q == ST_SEEK && !app_rdy_q)
        else $error("broken pattern did not restart detection");
    expire_a: assert property ( // [RQ4]
        clk_en && st_q == ST_COUNT && alt_ok && cnt_zero |=> app_rdy_q ##1 app_rdy_q)
        else $error("countdown expiry did not raise ready");
    early_ready_a: assert property ( // [RQ4]
        clk_en && st_q == ST_COUNT && !cnt_zero |=> !app_rdy_q)
        else $error("ready raised before countdown expired");
    crit_hold_a: assert property ( // [RQ5]
        $past(clk_en) && !$past(app_rdy_q) |-> crit_q == CRIT_IDLE)
        else $error("critical inputs not held while handoff pending");
    crit_pass_a: assert property ( // [RQ6]
        clk_en && app_rdy_q |=> crit_q == $past(user_crit_in))
        else $error("critical inputs not passed after handoff");
    done_pin_a: assert property ( // [RQ10]
        clk_en |=> cfg_done_q == $past(cfg_done_d))
        else $error("done indicator does not follow configuration state");
    drain_off_a: assert property ( // [RQ9]
        clk_en && app_rdy_q |=> !rx_ready)
        else $error("drain completer active after handoff");
    cov_handoff_c: cover property (st_q == ST_COUNT ##1 app_rdy_q);
    cov_restart_c: cover property (st_q == ST_COUNT && clk_en && !alt_ok);
endmodule

// >>> verification/pattern_gen.sv
`timescale 1ns/10ps
// second-stage word source, held off until told to run
module pattern_gen #(
    parameter logic [7:0] PAT_A = 8'h12,
    parameter logic [7:0] PAT_B = 8'h9A
) (
    // clock
    input wire logic sys_clk,
    // control
    input wire logic run,
    input wire logic brk,
    // word toward the first stage
    output logic [7:0] pattern_in
);
    logic ph_q = 1'b0;
    logic [6:0] junk_q = 7'h00;
    logic [7:0] word_q = 8'h01;
    // odd junk before start-up never equals the even pattern values
    always @(negedge sys_clk) begin // no reset from the shared bank
        junk_q <= junk_q + 7'h01;
        ph_q <= run ? ~ph_q : 1'b0;
        if (!run) begin
            word_q <= {junk_q, 1'b1};
        end else if (brk) begin
            word_q <= 8'h55;
        end else begin
            word_q <= ph_q ? PAT_B : PAT_A;
        end
    end
    // single driver for the word toward the first stage
    assign pattern_in = word_q;
endmodule

// >>> verification/staged_boot_handoff_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH %0t value differs", $time); end end
module staged_boot_handoff_tb;
    logic sys_clk = 1'b0, nrst = 1'b0, run = 1'b0, brk = 1'b0, clk_en = 1'b1;
    logic startup_pin = 1'b0, stage2_done_pin = 1'b0, cfg_done, app_rdy;
    logic [3:0] user_crit_in = 4'hA, crit_out;
    logic rx_valid = 1'b0, rx_read = 1'b0, rx_ready, cpl_valid, cpl_ready = 1'b0;
    logic [7:0] rx_tag = 8'h00, cpl_tag, pattern_in;
    logic [31:0] cpl_data;
    int err_count = 0, checks = 0, cyc = 0;
    staged_boot_handoff dut_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
        .pattern_in(pattern_in), .startup_pin(startup_pin),
        .stage2_done_pin(stage2_done_pin), .cfg_done(cfg_done), .app_rdy(app_rdy),
        .user_crit_in(user_crit_in), .crit_out(crit_out), .rx_valid(rx_valid),
        .rx_read(rx_read), .rx_tag(rx_tag), .rx_ready(rx_ready), .cpl_valid(cpl_valid),
        .cpl_tag(cpl_tag), .cpl_data(cpl_data), .cpl_ready(cpl_ready));
    pattern_gen gen_u (.sys_clk(sys_clk), .run(run), .brk(brk), .pattern_in(pattern_in));
    // clock and hang guard
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge sys_clk);
        nrst = 1'b0;
        run = 1'b0;
        repeat (16) @(negedge sys_clk);
        `CHK({app_rdy, crit_out, rx_ready, cpl_valid, cfg_done}, 8'h00)
        nrst = 1'b1;
        @(negedge sys_clk);
    endtask
    // one request held until taken, then judged
    task automatic send_req(input logic rd, input logic [7:0] tag);
        int n;
        n = 0;
        @(negedge sys_clk);
        rx_valid = 1'b1;
        rx_read = rd;
        rx_tag = tag;
        while (rx_ready !== 1'b1 && n < 50) begin @(negedge sys_clk); n++; end
        @(negedge sys_clk);
        rx_valid = 1'b0;
        rx_read = ~rd;
        rx_tag = ~tag;
        `CHK(cpl_valid, rd)
        if (rd) begin
            `CHK({cpl_tag, cpl_data, rx_ready}, {tag, 32'h0, 1'b0})
            repeat (2) @(negedge sys_clk);
            `CHK(cpl_valid, 1'b1)
            cpl_ready = 1'b1;
            @(negedge sys_clk);
            cpl_ready = 1'b0;
            `CHK({cpl_valid, rx_ready}, 2'b01)
        end
    endtask
    // done pin: pulse at first start-up, then level at stage two
    task automatic test_done();
        startup_pin = 1'b1;
        repeat (2) @(negedge sys_clk);
        `CHK(cfg_done, 1'b0)
        @(negedge sys_clk);
        `CHK(cfg_done, 1'b1)
        startup_pin = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK(cfg_done, 1'b0)
        stage2_done_pin = 1'b1;
        repeat (20) @(negedge sys_clk);
        `CHK(cfg_done, 1'b1)
    endtask
    // a broken sample mid-count must restart detection
    task automatic test_break();
        int n;
        run <= 1'b1;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (pattern_in !== 8'h9A && n < 20);
        repeat (30) @(negedge sys_clk);
        brk <= 1'b1;
        @(negedge sys_clk);
        brk <= 1'b0;
        repeat (45) @(negedge sys_clk);
        `CHK(app_rdy, 1'b0)
        n = 0;
        while (app_rdy !== 1'b1 && n < 200) begin @(negedge sys_clk); n++; end
        `CHK(app_rdy, 1'b1)
    endtask
    // exact countdown with an enable freeze, mux switch-over and drain shut-off
    task automatic test_exact();
        int n;
        run <= 1'b1;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (pattern_in !== 8'h9A && n < 20);
        // four frozen edges must push the handoff out by four
        repeat (10) @(negedge sys_clk);
        clk_en = 1'b0;
        repeat (4) @(negedge sys_clk);
        clk_en = 1'b1;
        repeat (53) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK({app_rdy, crit_out}, 5'h00)
        @(negedge sys_clk);
        `CHK({app_rdy, rx_ready}, 2'b10)
        user_crit_in = 4'h5;
        @(negedge sys_clk);
        `CHK(crit_out, 4'h5)
        rx_valid = 1'b1;
        rx_read = 1'b1;
        repeat (5) @(negedge sys_clk);
        `CHK({rx_ready, cpl_valid}, 2'b00)
        rx_valid = 1'b0;
    endtask
    initial begin
        do_reset();
        send_req(1'b0, 8'h3C);
        send_req(1'b1, 8'hA5);
        send_req(1'b1, 8'h07);
        test_done();
        test_break();
        do_reset();
        test_exact();
        stop_test();
    end
endmodule
